/* File: sim/udws_adapter_tb.sv */
// Purpose: Self-checking bench for the width sizing adapter, through a loopback lane model.
// Assumes: One interleaved transmit setup and one interleaved receive setup cover both halves.
// Notes: Outputs are combinational, so each check waits one nanosecond after driving.
`timescale 1ns/1ps
`default_nettype none
module udws_adapter_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    int mismatches = 0;
    int checks_done = 0;
    int cyc = 0;
    logic [79:0] ua = 80'h0;
    logic [31:0] ub = 32'h0;
    udws_pkg::udws_ctrl_t [1:0] ca = '0;
    udws_pkg::udws_ctrl_t [0:0] cb = '0;
    udws_pkg::udws_tx_lane_t [1:0] la;
    udws_pkg::udws_tx_lane_t [0:0] lb;
    udws_pkg::udws_rx_lane_t [1:0] ra;
    udws_pkg::udws_rx_lane_t [0:0] rb;
    logic [63:0] ra_user;
    logic [19:0] rb_user;
    udws_pkg::udws_ctrl_t [1:0] ra_ctrl;
    udws_pkg::udws_ctrl_t [0:0] rb_ctrl;
    always #5 clk = ~clk;
    udws_adapter #(.TX_W(40), .NCH(2)) udws_adapter_inst (.i_clk(clk), .i_rstn(rstn),
        .i_user_tx(ua), .i_user_tx_ctrl(ca), .o_lane_tx(la), .i_lane_rx(ra), .o_user_rx(ra_user),
        .o_user_rx_ctrl(ra_ctrl));
    udws_lane_model #(.NCH(2)) udws_lane_model_inst (.i_lane_tx(la), .o_lane_rx(ra));
    // Second instance name departs from the naming pattern, as two copies are needed.
    udws_adapter #(.RX_W(20), .NCH(1)) udws_adapter_inst2 (.i_clk(clk), .i_rstn(rstn),
        .i_user_tx(ub), .i_user_tx_ctrl(cb), .o_lane_tx(lb), .i_lane_rx(rb), .o_user_rx(rb_user),
        .o_user_rx_ctrl(rb_ctrl));
    udws_lane_model udws_lane_model_inst2 (.i_lane_tx(lb), .o_lane_rx(rb));
    function automatic udws_pkg::udws_tx_lane_t exp_lane(input logic [159:0] s, input int w, input bit il,
            input udws_pkg::udws_ctrl_t c);
        udws_pkg::udws_tx_lane_t l;
        l = {c.port_b, c.port_a, 128'h0};
        for (int k = 0; k < w; k++) begin
            if (!il) l.data[k] = s[k];
            else if (k % 10 < 8) l.data[8*(k/10)+k%10] = s[k];
            else if (k % 10 == 8) l.lane_transmit_control_port_a[k/10] = s[k];
            else l.lane_transmit_control_port_b[k/10] = s[k];
        end
        return l;
    endfunction : exp_lane
    function automatic logic [159:0] exp_user(input udws_pkg::udws_tx_lane_t l, input int w, input bit il);
        logic [159:0] u;
        u = 160'h0;
        for (int k = 0; k < w; k++) begin
            if (!il) u[k] = l.data[k];
            else if (k % 10 < 8) u[k] = l.data[8*(k/10)+k%10];
            else if (k % 10 == 8) u[k] = l.lane_transmit_control_port_a[k/10];
            else u[k] = l.lane_transmit_control_port_b[k/10];
        end
        return u;
    endfunction : exp_user
    task automatic check(input string n, input logic [159:0] s, input logic [159:0] e);
        checks_done++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic apply(input logic [79:0] a, input logic [63:0] ac, input logic [31:0] b, input logic [31:0] bc);
        udws_pkg::udws_tx_lane_t e;
        @(posedge clk);
        #1 ua = a;
        ca = ac;
        ub = b;
        cb = bc;
        #1;
        for (int c = 0; c < 2; c++) begin
            e = exp_lane(160'(a[c*40+:40]), 40, 1'b1, ca[c]);
            check("lane_tx_a", la[c], e);
            check("user_rx_a", 160'(ra_user[c*32+:32]), exp_user(e, 32, 1'b0));
            check("rx_ctrl_a", 160'(ra_ctrl[c]), 160'(e[159:128]));
        end
        e = exp_lane(160'(b), 32, 1'b0, cb[0]);
        check("lane_tx_b", lb[0], e);
        check("user_rx_b", 160'(rb_user), exp_user(e, 20, 1'b1));
        check("rx_ctrl_b", 160'(rb_ctrl[0]), 160'(e[159:128]));
    endtask : apply
    task automatic t_ones_tied_bits;
        apply({80{1'b1}}, 64'h0, 32'hFFFFFFFF, 32'h0);
        apply(80'h0, {64{1'b1}}, 32'h0, 32'hFFFFFFFF);
    endtask : t_ones_tied_bits
    task automatic t_walking_bit;
        for (int i = 0; i < 80; i++) apply(80'h1 << i, 64'h0, 32'h1 << (i % 32), 32'h0);
    endtask : t_walking_bit
    task automatic t_mixed_ctrl;
        apply(80'hA5A5_5A5A_0F0F_F0F0_3C3C, 64'h1234_5678_9ABC_DEF0, 32'hC3A5_5A3C, 32'h8421_7BDE);
    endtask : t_mixed_ctrl
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : print_verdict
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 rstn = 1'b1;
        t_ones_tied_bits();
        t_walking_bit();
        t_mixed_ctrl();
        print_verdict();
    end
endmodule : udws_adapter_tb
`default_nettype wire

/* File: sim/udws_lane_model.sv */
// Purpose: Lane model that loops each transmit lane back to its receive lane.
// Assumes: Lane carriers as the package declares them.
// Notes: Data bits 127:64 come back inverted, so a tap on unused bits shows.
`timescale 1ns/1ps
`default_nettype none
module udws_lane_model #(
    parameter int NCH = 1
) (
    input wire udws_pkg::udws_tx_lane_t [NCH-1:0] i_lane_tx,
    output wire udws_pkg::udws_rx_lane_t [NCH-1:0] o_lane_rx
);
    for (genvar c = 0; c < NCH; c++) begin : g_lane
        assign o_lane_rx[c] = {i_lane_tx[c][159:128], ~i_lane_tx[c][127:64], i_lane_tx[c][63:0]};
    end
endmodule : udws_lane_model
`default_nettype wire

/* File: src/udws_adapter.sv */
// Purpose: Pure wiring between packed user words and per-lane data and control ports.
// Assumes: Channel 0 is the lowest grid position; i_clk and i_rstn only time the checks.
// Notes: No flip-flop sits in the datapath; only the reset that arms the checks is synchronised.
`timescale 1ns/1ps
`default_nettype none
module udws_adapter #(
    parameter int TX_W = udws_pkg::DEFAULT_USER_W,
    parameter int RX_W = udws_pkg::DEFAULT_USER_W,
    parameter int NCH = udws_pkg::DEFAULT_CHANNELS
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    // RL5 transmit vector width.
    input wire logic [TX_W*NCH-1:0] i_user_tx,
    input wire udws_pkg::udws_ctrl_t [NCH-1:0] i_user_tx_ctrl,
    output wire udws_pkg::udws_tx_lane_t [NCH-1:0] o_lane_tx,
    input wire udws_pkg::udws_rx_lane_t [NCH-1:0] i_lane_rx,
    // RL10 receive vector width.
    output wire logic [RX_W*NCH-1:0] o_user_rx,
    output wire udws_pkg::udws_ctrl_t [NCH-1:0] o_user_rx_ctrl
);

    // Each ten-bit user group of an interleaved width is laid out as follows.
    // Bits 0 to 7 of the group go to eight consecutive bits of the lane data port.
    // Bit 8 of the group goes to one bit of control port a, at the group's index.
    // Bit 9 of the group goes to one bit of control port b, at the same index.
    // The data port is therefore filled only up to eight tenths of the user width.
    // Every other width is copied straight onto the low bits of the data port.

    // RL2 interleaved widths detected.
    localparam bit TX_IL = udws_pkg::udws_is_interleaved(TX_W);
    localparam bit RX_IL = udws_pkg::udws_is_interleaved(RX_W);
    localparam int TX_GROUPS = TX_W / udws_pkg::GROUP_W;
    localparam int RX_GROUPS = RX_W / udws_pkg::GROUP_W;
    localparam int TX_USED = TX_IL ? TX_GROUPS * udws_pkg::GROUP_DATA_W : TX_W;

    // RL4 transmit half only.
    // RL15 parameters pick wiring.
    for (genvar c = 0; c < NCH; c++) begin : g_tx
        // RL6 ascending channel slices.
        localparam int BASE = c * TX_W;
        for (genvar b = 0; b < udws_pkg::DATA_PORT_W; b++) begin : g_bit
            localparam int GRP = b / udws_pkg::GROUP_DATA_W;
            localparam int OFS = b % udws_pkg::GROUP_DATA_W;
            if (TX_IL && GRP < TX_GROUPS) begin : g_il
                // RL14 group data bits.
                assign o_lane_tx[c].data[b] = i_user_tx[BASE + GRP * udws_pkg::GROUP_W + OFS];
            end else if (!TX_IL && b < TX_W) begin : g_plain
                // RL7 slice onto data.
                assign o_lane_tx[c].data[b] = i_user_tx[BASE + b];
            end else begin : g_tie
                // RL1 unused bits tied.
                assign o_lane_tx[c].data[b] = 1'h0;
            end
        end
        for (genvar k = 0; k < udws_pkg::CTRL_PORT_W; k++) begin : g_ctl
            if (TX_IL && k < TX_GROUPS) begin : g_il
                // RL8 de-interleave control.
                assign o_lane_tx[c].lane_transmit_control_port_a[k] =
                    i_user_tx[BASE + k * udws_pkg::GROUP_W + udws_pkg::GROUP_CTRL_A_POS];
                assign o_lane_tx[c].lane_transmit_control_port_b[k] =
                    i_user_tx[BASE + k * udws_pkg::GROUP_W + udws_pkg::GROUP_CTRL_B_POS];
            end else begin : g_user
                // RL9 user drives control.
                assign o_lane_tx[c].lane_transmit_control_port_a[k] = i_user_tx_ctrl[c].port_a[k];
                assign o_lane_tx[c].lane_transmit_control_port_b[k] = i_user_tx_ctrl[c].port_b[k];
            end
        end
    end

    // RL4 receive half only.
    for (genvar c = 0; c < NCH; c++) begin : g_rx
        localparam int BASE = c * RX_W;
        // RL13 control stays visible.
        assign o_user_rx_ctrl[c].port_a = i_lane_rx[c].lane_receive_control_port_a;
        assign o_user_rx_ctrl[c].port_b = i_lane_rx[c].lane_receive_control_port_b;
        for (genvar i = 0; i < RX_W; i++) begin : g_bit
            localparam int GRP = i / udws_pkg::GROUP_W;
            localparam int OFS = i % udws_pkg::GROUP_W;
            if (!RX_IL) begin : g_plain
                // RL11 slice from data.
                assign o_user_rx[BASE + i] = i_lane_rx[c].data[i];
            end else if (OFS < udws_pkg::GROUP_DATA_W) begin : g_dat
                // RL12 merge data bits.
                assign o_user_rx[BASE + i] = i_lane_rx[c].data[GRP * udws_pkg::GROUP_DATA_W + OFS];
            end else if (OFS == udws_pkg::GROUP_CTRL_A_POS) begin : g_cta
                // RL14 control a position.
                assign o_user_rx[BASE + i] = i_lane_rx[c].lane_receive_control_port_a[GRP];
            end else begin : g_ctb
                assign o_user_rx[BASE + i] = i_lane_rx[c].lane_receive_control_port_b[GRP];
            end
        end
    end

    // Checks sample the wires on the clock; the datapath itself never uses it.
    // The pin reset is released through two flip-flops before it arms the checks, so a
    // release close to a clock edge cannot arm some checks one cycle before the others.
    logic [1:0] chk_sync;
    logic [1:0] next_chk_sync;
    logic chk_rstn;

    always_comb begin
        next_chk_sync = {chk_sync[0], i_rstn};
    end

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            chk_sync <= '0;
        end else begin
            chk_sync <= next_chk_sync;
        end
    end

    // Only the second flip-flop is read, so the first may settle from a metastable state.
    assign chk_rstn = chk_sync[1];

    for (genvar c = 0; c < NCH; c++) begin : g_chk
        // Bits above the used width must read zero, or the lane would send stale data.
        a_tx_unused_zero: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL1
            (o_lane_tx[c].data >> TX_USED) == '0) else $error("unused transmit bits not zero");

        // Receive control is a straight copy in every configuration.
        a_rx_ctrl_visible: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL13
            o_user_rx_ctrl[c].port_a == i_lane_rx[c].lane_receive_control_port_a
            && o_user_rx_ctrl[c].port_b == i_lane_rx[c].lane_receive_control_port_b)
            else $error("receive control not visible");

        // User control inputs must never reach the data port of a lane.
        a_tx_data_hold: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL4
            $stable(i_user_tx)
            |-> $stable(o_lane_tx[c].data))
            else $error("transmit data moved without user word");

        if (!TX_IL) begin : g_tx_plain
            a_tx_data_map: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL7
                o_lane_tx[c].data[TX_W-1:0] == i_user_tx[c*TX_W +: TX_W]) else $error("transmit slice misplaced");

            a_tx_ctrl_user: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL9
                o_lane_tx[c].lane_transmit_control_port_a == i_user_tx_ctrl[c].port_a
                && o_lane_tx[c].lane_transmit_control_port_b == i_user_tx_ctrl[c].port_b)
                else $error("transmit control not from user");
        end else begin : g_tx_il
            // Spare control bits above the used groups stay with user logic.
            for (genvar k = TX_GROUPS; k < udws_pkg::CTRL_PORT_W; k++) begin : g_free
                a_tx_ctrl_spare: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL9
                    o_lane_tx[c].lane_transmit_control_port_a[k] == i_user_tx_ctrl[c].port_a[k]
                    && o_lane_tx[c].lane_transmit_control_port_b[k] == i_user_tx_ctrl[c].port_b[k])
                    else $error("spare transmit control not from user");
            end

            for (genvar k = 0; k < TX_GROUPS; k++) begin : g_grp
                a_tx_il_group: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL8
                    {o_lane_tx[c].lane_transmit_control_port_b[k], o_lane_tx[c].lane_transmit_control_port_a[k],
                     o_lane_tx[c].data[k*udws_pkg::GROUP_DATA_W +: udws_pkg::GROUP_DATA_W]}
                    == i_user_tx[c*TX_W + k*udws_pkg::GROUP_W +: udws_pkg::GROUP_W])
                    else $error("transmit group not de-interleaved");
            end
        end

        if (!RX_IL) begin : g_rx_plain
            a_rx_data_map: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL11
                o_user_rx[c*RX_W +: RX_W] == i_lane_rx[c].data[RX_W-1:0]) else $error("receive slice misplaced");
        end else begin : g_rx_il
            for (genvar k = 0; k < RX_GROUPS; k++) begin : g_grp
                a_rx_il_merge: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL12
                    o_user_rx[c*RX_W + k*udws_pkg::GROUP_W +: udws_pkg::GROUP_W]
                    == {i_lane_rx[c].lane_receive_control_port_b[k], i_lane_rx[c].lane_receive_control_port_a[k],
                        i_lane_rx[c].data[k*udws_pkg::GROUP_DATA_W +: udws_pkg::GROUP_DATA_W]})
                    else $error("receive group not merged");
            end
        end
    end

    // Outputs may change only in the cycle in which an input does.
    // A register slipped into either path would show up here as a one-cycle lag.
    a_tx_no_latency: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL3
        $stable(i_user_tx) && $stable(i_user_tx_ctrl) |-> $stable(o_lane_tx)) else $error("transmit output moved alone");

    a_rx_no_latency: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL3
        $changed(o_user_rx) |-> $changed(i_lane_rx)) else $error("receive output lagged its input");

    a_tx_follows: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL3
        $changed(o_lane_tx)
        |-> $changed(i_user_tx) || $changed(i_user_tx_ctrl))
        else $error("transmit output lagged its input");

    a_rx_holds: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL4
        $stable(i_lane_rx)
        |-> $stable(o_user_rx) && $stable(o_user_rx_ctrl))
        else $error("receive output moved without lane input");

    a_rx_ctrl_follows: assert property (@(posedge i_clk) disable iff (!chk_rstn) // RL13
        $changed(o_user_rx_ctrl)
        |-> $changed(i_lane_rx))
        else $error("receive control lagged its input");

    // The covers show that each direction saw traffic, back to back as well.
    c_tx_word: cover property (@(posedge i_clk) disable iff (!chk_rstn) $changed(i_user_tx) ##1 $changed(i_user_tx));
    c_rx_word: cover property (@(posedge i_clk) disable iff (!chk_rstn) $changed(o_user_rx));
    c_rx_ctrl: cover property (@(posedge i_clk) disable iff (!chk_rstn) $changed(o_user_rx_ctrl));
    c_tx_ctrl: cover property (@(posedge i_clk) disable iff (!chk_rstn) $changed(i_user_tx_ctrl));
    c_rx_lane: cover property (@(posedge i_clk) disable iff (!chk_rstn) $changed(i_lane_rx) ##1 $changed(i_lane_rx));

endmodule : udws_adapter
`default_nettype wire

/* File: src/udws_pkg.sv */
// Purpose: Constants and carrier types for the user data width sizing adapter.
// Assumes: Lane control ports are sixteen bits wide, enough for sixteen ten-bit groups.
// Notes: Operation list follows.
// Operation
// RL1: Lane data ports are 128 bits; unused transmit bits tied low, unused receive ignored.
// RL2: Widths 20, 40, 80, 160 interleave control port bits with data.
// RL3: Adapter is continuous wire assignments only, adding no delay.
// RL4: Transmit and receive halves are independent and share no signals.
// RL5: Transmit user vector is transmit width times enabled channel count.
// RL6: Lowest user slice maps to lowest bits of lowest-position channel, ascending.
// RL7: Each transmit slice lands on the used bits of its lane data port.
// RL8: Interleaved transmit widths also drive both control ports, de-interleaving the slice.
// RL9: Non-interleaved transmit widths leave control ports to user logic.
// RL10: Receive user vector is receive width times enabled channel count.
// RL11: Each receive slice is filled from the used bits of its lane data port.
// RL12: Interleaved receive widths merge both control ports with data bits.
// RL13: Receive control ports stay visible to user logic in every configuration.
// RL14: Ten-bit group k holds data 8k..8k+7, then control a bit k, then b bit k.
// RL15: Transmit width, receive width and channel count are elaboration parameters.
package udws_pkg;

    localparam int DATA_PORT_W = 128;
    localparam int CTRL_PORT_W = 16;
    localparam int GROUP_W = 10;
    localparam int GROUP_DATA_W = 8;
    localparam int GROUP_CTRL_A_POS = 8;
    localparam int GROUP_CTRL_B_POS = 9;
    localparam int IL_W20 = 20;
    localparam int IL_W40 = 40;
    localparam int IL_W80 = 80;
    localparam int IL_W160 = 160;
    localparam int DEFAULT_USER_W = 32;
    localparam int DEFAULT_CHANNELS = 4;

    typedef struct packed {
        logic [CTRL_PORT_W-1:0] lane_transmit_control_port_b;
        logic [CTRL_PORT_W-1:0] lane_transmit_control_port_a;
        logic [DATA_PORT_W-1:0] data;
    } udws_tx_lane_t;

    typedef struct packed {
        logic [CTRL_PORT_W-1:0] lane_receive_control_port_b;
        logic [CTRL_PORT_W-1:0] lane_receive_control_port_a;
        logic [DATA_PORT_W-1:0] data;
    } udws_rx_lane_t;

    typedef struct packed {
        logic [CTRL_PORT_W-1:0] port_b;
        logic [CTRL_PORT_W-1:0] port_a;
    } udws_ctrl_t;

    function automatic bit udws_is_interleaved(input int width);
        return (width == IL_W20) || (width == IL_W40) || (width == IL_W80) || (width == IL_W160);
    endfunction : udws_is_interleaved

endpackage : udws_pkg
